// ---- verilog/sfp_manager.sv ----
// Fault supervision and shutdown sequencing for a USB PD source output.
`timescale 1ns/10ps
`include "sfp_defines.svh"

// Summary of operation
// - Voltage sample is VBUS divided by ten
// - Fault drops CC pull-up, opens switch
// - After clear, wait restart at 5V target, reattach at reqVoltMv
// - Over-voltage above 120% for debounce time
// - Restart timer starts when over-voltage clears
// - Over-voltage ignored during blanking after change
// - Under-voltage below 65% for debounce time
// - Under-voltage never requests an Alert
// - Ratio under-voltage ignored during blanking after change
// - Ratio under-voltage off in PPS contracts
// - Absolute floor under-voltage in every contract
// - Floor fault latched until below release level
// - Fixed contracts trip at 120% current
// - Overcurrent Alert after contract, history flag kept
// - PPS uses current limiting, no overcurrent trip
// - Alert on CL/CV mode transitions only while running in a PPS contract
// - PPS status: mode flag, voltage, current
// - Thermistor temperature reported in status
// - Temperature warning Alert, no fault
// - Over-temperature takes common shutdown path
// - Over-temperature Alert after contract restored
// - Cable power overcurrent: VCONN off, 3A caps
module sfp_manager #(
  parameter logic [`SFP_CNT_W-1:0] RESTART_CYCLES = `SFP_CNT_W'(`SFP_RESTART_CYC),
  parameter logic [`SFP_CNT_W-1:0] OV_BLANK_CYCLES = `SFP_CNT_W'(`SFP_OV_BLANK_CYC),
  parameter logic [`SFP_CNT_W-1:0] UV_BLANK_CYCLES = `SFP_CNT_W'(`SFP_UV_BLANK_CYC)
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Measurements, millivolts of divided output, milliamps, degrees C
  input  wire logic [15:0] outVoltDivMv,
  input  wire logic [15:0] loadCurrentMa,
  input  wire logic [9:0]  thermTempC,
  input  wire logic        thermPresent,
  // Contract from policy logic
  input  wire logic [15:0] reqVoltMv,
  input  wire logic [15:0] reqCurrentMa,
  input  wire logic        ppsContract,
  input  wire logic        voltChangeStb,
  input  wire logic        explicitContract,
  input  wire logic        alertTaken,
  // Thresholds in divided millivolts
  input  wire logic [15:0] floorThreshMv,
  input  wire logic [15:0] latchReleaseMv,
  // Asynchronous comparator pins
  input  wire logic        cableOcPin,
  input  wire logic        currentLimitPin,
  // Power path controls
  output logic             ccPullupEn,
  output logic             vbusSwitchEn,
  output logic             vconnEn,
  output logic             cableLimited3A,
  output logic [15:0]      targetVoltMv,
  output logic             ccLimitMode,
  // Status and Alert content
  output logic             alertReq,
  output logic             alertOcp,
  output logic             alertOtp,
  output logic             alertTempWarn,
  output logic             alertModeChange,
  output logic             ocpHistory,
  output logic [15:0]      statusVoltMv,
  output logic [15:0]      statusCurrentMa,
  output logic [9:0]       statusTempC,
  output logic             outputOvervoltageFault,
  output logic             outputUndervoltageFault,
  output logic             overTempFault
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] cableOcSync;
  logic [2:0] limitSync;
  logic       cableOc;
  logic       limitLevel;
  always_ff @(posedge clk) begin
    if (srst) begin
      cableOcSync <= 3'h0;
      limitSync   <= 3'h0;
      cableOc     <= 1'b0;
      limitLevel  <= 1'b0;
    end else begin
      cableOcSync <= {cableOcSync[1:0], cableOcPin};
      limitSync   <= {limitSync[1:0], currentLimitPin};
      if (cableOcSync[1] == cableOcSync[2]) cableOc <= cableOcSync[2];
      if (limitSync[1] == limitSync[2]) limitLevel <= limitSync[2];
    end
  end

  // ----------------------------------------------------------------
  // Raw comparisons
  // ----------------------------------------------------------------
  // Products are widened so the percentage scaling cannot overflow.
  // With the switch open the output reads zero, so the low-side checks are
  // gated by the switch; otherwise a shutdown would hold itself forever.
  logic [31:0] measScaled;
  logic [31:0] curScaled;
  logic        ovRaw;
  logic        uvRatioRaw;
  logic        floorRaw;
  logic        ocRaw;
  assign measScaled = 32'(outVoltDivMv) * 32'(`SFP_VOLT_DIV) * 32'(`SFP_PCT_FULL);
  assign curScaled  = 32'(loadCurrentMa) * 32'(`SFP_PCT_FULL);
  assign ovRaw      = measScaled > 32'(reqVoltMv) * 32'(`SFP_OV_PCT);
  assign uvRatioRaw = !ppsContract && vbusSwitchEn &&
                      measScaled < 32'(reqVoltMv) * 32'(`SFP_UV_PCT);
  assign floorRaw   = vbusSwitchEn && outVoltDivMv < floorThreshMv;
  assign ocRaw      = !ppsContract &&
                      curScaled > 32'(reqCurrentMa) * 32'(`SFP_OC_PCT);

  // ----------------------------------------------------------------
  // Blanking after a commanded voltage change
  // ----------------------------------------------------------------
  logic [`SFP_CNT_W-1:0] ovBlankCnt;
  logic [`SFP_CNT_W-1:0] uvBlankCnt;
  always_ff @(posedge clk) begin
    if (srst) begin
      ovBlankCnt <= '0;
      uvBlankCnt <= '0;
    end else if (voltChangeStb) begin
      ovBlankCnt <= OV_BLANK_CYCLES;
      uvBlankCnt <= UV_BLANK_CYCLES;
    end else begin
      if (ovBlankCnt != '0) ovBlankCnt <= ovBlankCnt - 1'b1;
      if (uvBlankCnt != '0) uvBlankCnt <= uvBlankCnt - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Debounce counters
  // ----------------------------------------------------------------
  logic [`SFP_CNT_W-1:0] ovCnt;
  logic [`SFP_CNT_W-1:0] uvCnt;
  logic [`SFP_CNT_W-1:0] warnCnt;
  logic [`SFP_CNT_W-1:0] otCnt;
  logic ovCond;
  logic uvCond;
  logic warnCond;
  logic otCond;
  logic ovQual;
  logic uvQual;
  logic warnQual;
  logic otQual;
  assign ovCond   = ovRaw && ovBlankCnt == '0;
  assign uvCond   = uvRatioRaw && uvBlankCnt == '0;
  assign warnCond = thermPresent && thermTempC > `SFP_TEMP_WARN_C;
  assign otCond   = thermPresent && thermTempC > `SFP_TEMP_OT_C;
  assign ovQual   = ovCnt >= `SFP_CNT_W'(`SFP_OV_DEB_CYC);
  assign uvQual   = uvCnt >= `SFP_CNT_W'(`SFP_UV_DEB_CYC);
  assign warnQual = warnCnt >= `SFP_CNT_W'(`SFP_TEMP_DEB_CYC);
  assign otQual   = otCnt >= `SFP_CNT_W'(`SFP_TEMP_DEB_CYC);
  always_ff @(posedge clk) begin
    if (srst) begin
      ovCnt   <= '0;
      uvCnt   <= '0;
      warnCnt <= '0;
      otCnt   <= '0;
    end else begin
      ovCnt   <= !ovCond ? '0 : (ovQual ? ovCnt : ovCnt + 1'b1);
      uvCnt   <= !uvCond ? '0 : (uvQual ? uvCnt : uvCnt + 1'b1);
      warnCnt <= !warnCond ? '0 : (warnQual ? warnCnt : warnCnt + 1'b1);
      otCnt   <= !otCond ? '0 : (otQual ? otCnt : otCnt + 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Floor latch
  // ----------------------------------------------------------------
  logic floorLatched;
  always_ff @(posedge clk) begin
    if (srst) floorLatched <= 1'b0;
    else if (floorRaw && !floorLatched) floorLatched <= 1'b1;
    else if (outVoltDivMv < latchReleaseMv) floorLatched <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Fault sequencer
  // ----------------------------------------------------------------
  logic anyFault;
  logic faultActive;
  assign anyFault    = ovQual || uvQual || floorRaw || ocRaw || otQual;
  assign faultActive = anyFault || floorLatched;

  sfp_pkg::sfp_state_t   state;
  logic [`SFP_CNT_W-1:0] restartCnt;
  always_ff @(posedge clk) begin
    if (srst) begin
      state      <= sfp_pkg::SFP_RUN;
      restartCnt <= '0;
    end else begin
      case (state)
        sfp_pkg::SFP_RUN: begin
          if (anyFault) state <= sfp_pkg::SFP_FAULT;
        end
        sfp_pkg::SFP_FAULT: begin
          if (!faultActive) begin
            state      <= sfp_pkg::SFP_RESTART;
            restartCnt <= RESTART_CYCLES;
          end
        end
        sfp_pkg::SFP_RESTART: begin
          if (faultActive) state <= sfp_pkg::SFP_FAULT;
          else if (restartCnt <= `SFP_CNT_W'(1)) state <= sfp_pkg::SFP_RUN;
          else restartCnt <= restartCnt - 1'b1;
        end
        default: state <= sfp_pkg::SFP_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power path and cable power
  // ----------------------------------------------------------------
  // The target voltage returns to the start level on every shutdown and takes reqVoltMv again on reattach.
  always_ff @(posedge clk) begin
    if (srst) begin
      ccPullupEn   <= 1'b1;
      vbusSwitchEn <= 1'b1;
      targetVoltMv <= `SFP_START_MV;
    end else begin
      ccPullupEn   <= state == sfp_pkg::SFP_RUN && !anyFault;
      vbusSwitchEn <= state == sfp_pkg::SFP_RUN && !anyFault;
      targetVoltMv <= (state == sfp_pkg::SFP_RUN && !anyFault) ? reqVoltMv
                      : `SFP_START_MV;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vconnEn        <= 1'b1;
      cableLimited3A <= 1'b0;
    end else if (cableOc) begin
      vconnEn        <= 1'b0;
      cableLimited3A <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Alert requests and status content
  // ----------------------------------------------------------------
  // A pending event is consumed once its Alert flag is up, so one take clears it;
  // a new event arriving with alertTaken wins. Under-voltage never sets an Alert.
  logic ocpPend;
  logic otpPend;
  logic modePrev;
  logic modeEdge;
  logic warnPrev;
  assign modeEdge = ppsContract && state == sfp_pkg::SFP_RUN && limitLevel != modePrev;
  always_ff @(posedge clk) begin
    if (srst) begin
      ocpPend         <= 1'b0;
      otpPend         <= 1'b0;
      ocpHistory      <= 1'b0;
      modePrev        <= 1'b0;
      warnPrev        <= 1'b0;
      alertOcp        <= 1'b0;
      alertOtp        <= 1'b0;
      alertTempWarn   <= 1'b0;
      alertModeChange <= 1'b0;
    end else begin
      modePrev <= limitLevel;
      warnPrev <= warnQual;
      if (ocRaw) ocpHistory <= 1'b1;
      if (ocRaw) ocpPend <= 1'b1;
      else if (alertOcp) ocpPend <= 1'b0;
      if (otQual) otpPend <= 1'b1;
      else if (alertOtp) otpPend <= 1'b0;
      if (ocpPend && explicitContract && state == sfp_pkg::SFP_RUN) alertOcp <= 1'b1;
      else if (alertTaken) alertOcp <= 1'b0;
      if (otpPend && explicitContract && state == sfp_pkg::SFP_RUN) alertOtp <= 1'b1;
      else if (alertTaken) alertOtp <= 1'b0;
      if (warnQual && !warnPrev) alertTempWarn <= 1'b1;
      else if (alertTaken) alertTempWarn <= 1'b0;
      if (modeEdge) alertModeChange <= 1'b1;
      else if (alertTaken) alertModeChange <= 1'b0;
    end
  end
  assign alertReq = alertOcp || alertOtp || alertTempWarn || alertModeChange;

  always_ff @(posedge clk) begin
    if (srst) begin
      ccLimitMode             <= 1'b0;
      statusVoltMv            <= 16'h0000;
      statusCurrentMa         <= 16'h0000;
      statusTempC             <= 10'h000;
      outputOvervoltageFault  <= 1'b0;
      outputUndervoltageFault <= 1'b0;
      overTempFault           <= 1'b0;
    end else begin
      ccLimitMode             <= ppsContract && limitLevel;
      statusVoltMv            <= 16'(measScaled / 32'(`SFP_PCT_FULL));
      statusCurrentMa         <= loadCurrentMa;
      statusTempC             <= thermPresent ? thermTempC : 10'h000;
      outputOvervoltageFault  <= ovQual;
      outputUndervoltageFault <= uvQual || floorRaw || floorLatched;
      overTempFault           <= otQual;
    end
  end

endmodule : sfp_manager

// ---- verilog/sfp_defines.svh ----
// Timing, threshold and field constants for the source fault protection manager.
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH
`define SFP_CLK_MHZ          200
`define SFP_OV_DEB_US        10
`define SFP_UV_DEB_US        10
`define SFP_OV_BLANK_US      100
`define SFP_UV_BLANK_US      100
`define SFP_TEMP_DEB_US      100
`define SFP_RESTART_MS       2000
`define SFP_OV_DEB_CYC       (`SFP_OV_DEB_US * `SFP_CLK_MHZ)
`define SFP_UV_DEB_CYC       (`SFP_UV_DEB_US * `SFP_CLK_MHZ)
`define SFP_OV_BLANK_CYC     (`SFP_OV_BLANK_US * `SFP_CLK_MHZ)
`define SFP_UV_BLANK_CYC     (`SFP_UV_BLANK_US * `SFP_CLK_MHZ)
`define SFP_TEMP_DEB_CYC     (`SFP_TEMP_DEB_US * `SFP_CLK_MHZ)
`define SFP_RESTART_CYC      (`SFP_RESTART_MS * 1000 * `SFP_CLK_MHZ)
`define SFP_OV_PCT           120
`define SFP_UV_PCT           65
`define SFP_OC_PCT           120
`define SFP_PCT_FULL         100
`define SFP_VOLT_DIV         10
`define SFP_TEMP_WARN_C      10'h064
`define SFP_TEMP_OT_C        10'h06E
`define SFP_START_MV         16'h1388
`define SFP_CNT_W            40
`endif

// ---- verilog/sfp_pkg.sv ----
// Types for the source fault protection manager.
package sfp_pkg;
  typedef enum logic [2:0] {
    SFP_RUN     = 3'b001,
    SFP_FAULT   = 3'b010,
    SFP_RESTART = 3'b100
  } sfp_state_t;
endpackage : sfp_pkg

// ---- bench/sfp_manager_checker.sv ----
// Port-level assertions for the source fault protection manager.
`timescale 1ns/10ps
module sfp_manager_checker #(
  parameter logic [39:0] RESTART_CYCLES = 40'h32
) (
  // Clock, reset and stimulus
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [15:0] outVoltDivMv,
  input wire logic [15:0] reqVoltMv,
  input wire logic        ppsContract,
  input wire logic        voltChangeStb,
  input wire logic        alertTaken,
  input wire logic        cableOcPin,
  // Design outputs
  input wire logic        ccPullupEn,
  input wire logic        vbusSwitchEn,
  input wire logic        vconnEn,
  input wire logic        cableLimited3A,
  input wire logic [15:0] targetVoltMv,
  input wire logic        ccLimitMode,
  input wire logic        alertReq,
  input wire logic        alertOcp,
  input wire logic        alertModeChange,
  input wire logic        outputOvervoltageFault,
  input wire logic        outputUndervoltageFault,
  input wire logic        overTempFault
);
  logic [39:0] ovRun;
  logic [39:0] uvRun;
  logic [39:0] quiet;
  logic        anyFault;
  logic        ovCond;
  logic        uvCond;
  assign anyFault = outputOvervoltageFault || outputUndervoltageFault || overTempFault;
  assign ovCond   = 32'(outVoltDivMv) * 32'h3E8 > 32'(reqVoltMv) * 32'h78;
  // An open switch reads zero volts; that is a shutdown, not an under-voltage.
  assign uvCond   = vbusSwitchEn && !ppsContract &&
                    32'(outVoltDivMv) * 32'h3E8 < 32'(reqVoltMv) * 32'h41;
  // A strobe restarts the runs, because blanking may only ever delay a trip.
  always_ff @(posedge clk) begin
    ovRun <= (srst || !ovCond || voltChangeStb) ? 40'h0 : ovRun + 40'h1;
  end
  always_ff @(posedge clk) begin
    uvRun <= (srst || !uvCond || voltChangeStb) ? 40'h0 : uvRun + 40'h1;
  end
  always_ff @(posedge clk) begin
    quiet <= (srst || vbusSwitchEn || anyFault) ? 40'h0 : quiet + 40'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  fault_cuts_power_a: assert property (anyFault |=> !vbusSwitchEn && !ccPullupEn)
    else $error("power path stayed on during a fault");
  off_at_5v_a: assert property (!vbusSwitchEn |-> targetVoltMv == 16'h1388)
    else $error("restart target is not 5 V");
  restart_wait_a: assert property ($rose(vbusSwitchEn) |->
    quiet + 40'h2 >= RESTART_CYCLES && quiet <= RESTART_CYCLES + 40'h4)
    else $error("restart interval wrong");
  ov_debounce_a: assert property ($rose(outputOvervoltageFault) |-> ovRun >= 40'h7CB)
    else $error("over-voltage tripped before debounce");
  uv_qualify_a: assert property (uvRun >= 40'h7EE |-> outputUndervoltageFault)
    else $error("under-voltage not raised");
  uv_no_alert_a: assert property ($rose(outputUndervoltageFault) && !alertReq |=>
    !alertReq [*4])
    else $error("under-voltage requested an alert");
  ocp_alert_hold_a: assert property (alertOcp && !alertTaken |=> alertOcp)
    else $error("overcurrent alert dropped early");
  mode_alert_a: assert property (ppsContract && vbusSwitchEn && $changed(ccLimitMode) &&
    !alertTaken |-> ##[0:2] alertModeChange)
    else $error("mode change gave no alert");
  cable_oc_a: assert property (cableOcPin [*8] |-> !vconnEn && cableLimited3A)
    else $error("cable supply not cut");
  ov_trip_c: cover property ($rose(outputOvervoltageFault));
  restart_c: cover property ($rose(vbusSwitchEn));
  mode_c: cover property ($rose(alertModeChange));
endmodule : sfp_manager_checker

// ---- bench/sfp_sink_model.sv ----
// Behavioural sink load across the cable.
`timescale 1ns/10ps
module sfp_sink_model (
  // Source power path
  input  wire logic [15:0] targetVoltMv,
  input  wire logic        vbusSwitchEn,
  // Load set by the bench: output in ten-thousandths of target, drawn current
  input  wire logic [15:0] voltPermil,
  input  wire logic [15:0] drawMa,
  // Sensed values
  output logic      [15:0] outVoltDivMv,
  output logic      [15:0] loadCurrentMa
);
  // The output discharges to zero once the switch opens, so no stale level lingers.
  always_comb begin
    outVoltDivMv  = vbusSwitchEn ? 16'(32'(targetVoltMv) * 32'(voltPermil) / 32'h186A0) : 16'h0;
    loadCurrentMa = vbusSwitchEn ? drawMa : 16'h0;
  end
endmodule : sfp_sink_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the source fault protection manager.
`timescale 1ns/10ps
module tb_top;
  logic        clk, srst, thermPresent, ppsContract, voltChangeStb, explicitContract;
  logic        alertTaken, cableOcPin, currentLimitPin, ccPullupEn, vbusSwitchEn, vconnEn;
  logic        cableLimited3A, ccLimitMode, alertReq, alertOcp, alertOtp, alertTempWarn;
  logic        alertModeChange, ocpHistory, outputOvervoltageFault, outputUndervoltageFault;
  logic        overTempFault;
  logic [9:0]  thermTempC, statusTempC;
  logic [15:0] outVoltDivMv, loadCurrentMa, reqVoltMv, reqCurrentMa, floorThreshMv;
  logic [15:0] latchReleaseMv, targetVoltMv, statusVoltMv, statusCurrentMa, voltPermil, drawMa;
  int          mismatches = 0;
  int          totalChecks = 0;
  sfp_manager #(.RESTART_CYCLES(40'h32), .OV_BLANK_CYCLES(40'hA), .UV_BLANK_CYCLES(40'hA))
  sfp_manager_i (.clk(clk), .srst(srst), .outVoltDivMv(outVoltDivMv),
    .loadCurrentMa(loadCurrentMa), .thermTempC(thermTempC), .thermPresent(thermPresent),
    .reqVoltMv(reqVoltMv), .reqCurrentMa(reqCurrentMa), .ppsContract(ppsContract),
    .voltChangeStb(voltChangeStb), .explicitContract(explicitContract),
    .alertTaken(alertTaken), .floorThreshMv(floorThreshMv), .latchReleaseMv(latchReleaseMv),
    .cableOcPin(cableOcPin), .currentLimitPin(currentLimitPin), .ccPullupEn(ccPullupEn),
    .vbusSwitchEn(vbusSwitchEn), .vconnEn(vconnEn), .cableLimited3A(cableLimited3A),
    .targetVoltMv(targetVoltMv), .ccLimitMode(ccLimitMode), .alertReq(alertReq),
    .alertOcp(alertOcp), .alertOtp(alertOtp), .alertTempWarn(alertTempWarn),
    .alertModeChange(alertModeChange), .ocpHistory(ocpHistory), .statusVoltMv(statusVoltMv),
    .statusCurrentMa(statusCurrentMa), .statusTempC(statusTempC),
    .outputOvervoltageFault(outputOvervoltageFault),
    .outputUndervoltageFault(outputUndervoltageFault), .overTempFault(overTempFault));
  sfp_sink_model sfp_sink_model_i (.targetVoltMv(targetVoltMv), .vbusSwitchEn(vbusSwitchEn),
    .voltPermil(voltPermil), .drawMa(drawMa), .outVoltDivMv(outVoltDivMv),
    .loadCurrentMa(loadCurrentMa));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tallyAndFinish
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic waitSw(input logic lvl, input int lim);
    for (int n = 0; n < lim && vbusSwitchEn !== lvl; n++)
      step(1);
    chk("switch", 16'(lvl), 16'(vbusSwitchEn));
    if (vbusSwitchEn !== lvl)
      tallyAndFinish();
  endtask : waitSw
  task automatic take();
    alertTaken = 1'b1;
    step(1);
    alertTaken = 1'b0;
    step(1);
  endtask : take
  initial begin
    {srst, thermPresent, explicitContract} = 3'h7;
    {ppsContract, voltChangeStb, alertTaken, cableOcPin, currentLimitPin} = 5'h0;
    thermTempC = 10'h019;
    {reqVoltMv, reqCurrentMa, voltPermil, drawMa} = {16'h1388, 16'hBB8, 16'h2710, 16'h3E8};
    {floorThreshMv, latchReleaseMv} = {16'h12C, 16'h64};
    step(8);
    srst = 1'b0;
    step(1);
    chk("reset target", 16'h1388, targetVoltMv);
    chk("reset pullup", 16'h1, 16'(ccPullupEn));
    voltPermil = 16'h32C8;
    step(1500);
    voltPermil = 16'h2710;
    step(1);
    // The second run starts with a strobe, so blanking must delay the trip.
    {voltChangeStb, voltPermil} = {1'b1, 16'h32C8};
    step(1);
    voltChangeStb = 1'b0;
    step(2003);
    chk("ov early", 16'h0, 16'(outputOvervoltageFault));
    waitSw(1'b0, 40);
    voltPermil = 16'h2710;
    chk("ov fault", 16'h1, 16'(outputOvervoltageFault));
    chk("pullup off", 16'h0, 16'(ccPullupEn));
    step(40);
    chk("still off", 16'h0, 16'(vbusSwitchEn));
    waitSw(1'b1, 30);
    $display("test overvoltage done");
    thermTempC = 10'h065;
    step(19900);
    chk("warn early", 16'h0, 16'(alertTempWarn));
    step(200);
    chk("warn", 16'h1, 16'(alertTempWarn));
    chk("no ot", 16'h0, 16'(overTempFault));
    chk("temp", 16'h65, 16'(statusTempC));
    take();
    chk("warn cleared", 16'h0, 16'(alertTempWarn));
    explicitContract = 1'b0;
    thermTempC = 10'h06F;
    waitSw(1'b0, 20100);
    chk("ot fault", 16'h1, 16'(overTempFault));
    thermTempC = 10'h019;
    waitSw(1'b1, 80);
    chk("otp early", 16'h0, 16'(alertOtp));
    explicitContract = 1'b1;
    step(3);
    chk("otp alert", 16'h1, 16'(alertOtp));
    take();
    chk("otp cleared", 16'h0, 16'(alertOtp));
    $display("test temperature done");
    drawMa = 16'hDAC;
    step(100);
    chk("below trip", 16'h1, 16'(vbusSwitchEn));
    explicitContract = 1'b0;
    drawMa = 16'hE74;
    waitSw(1'b0, 3000);
    drawMa = 16'h3E8;
    waitSw(1'b1, 80);
    explicitContract = 1'b1;
    step(3);
    chk("ocp alert", 16'h1, 16'(alertOcp));
    take();
    chk("ocp cleared", 16'h0, 16'(alertOcp));
    chk("ocp history", 16'h1, 16'(ocpHistory));
    $display("test overcurrent done");
    {ppsContract, voltChangeStb, reqVoltMv, drawMa} = {2'h3, 16'h2328, 16'h1388};
    step(1);
    voltChangeStb = 1'b0;
    step(3000);
    chk("pps no trip", 16'h1, 16'(vbusSwitchEn));
    chk("status volt", 16'h2328, statusVoltMv);
    chk("status amps", 16'h1388, statusCurrentMa);
    for (int m = 1; m >= 0; m--) begin
      currentLimitPin = 1'(m);
      step(8);
      chk("mode", 16'(m), 16'(ccLimitMode));
      chk("mode alert", 16'h1, 16'(alertModeChange));
      take();
      chk("mode cleared", 16'h0, 16'(alertModeChange));
    end
    voltPermil = 16'h1388;
    step(2100);
    chk("pps ratio", 16'h0, 16'(outputUndervoltageFault));
    voltPermil = 16'hBB8;
    waitSw(1'b0, 10);
    chk("floor uv", 16'h1, 16'(outputUndervoltageFault));
    chk("uv alert", 16'h0, 16'(alertReq));
    voltPermil = 16'h2710;
    waitSw(1'b1, 80);
    cableOcPin = 1'b1;
    step(8);
    chk("vconn", 16'h0, 16'(vconnEn));
    chk("cable 3A", 16'h1, 16'(cableLimited3A));
    chk("kept on", 16'h1, 16'(vbusSwitchEn));
    cableOcPin = 1'b0;
    $display("test pps done");
    // The PPS draw is dropped too, or the fixed contract would trip on current.
    {ppsContract, voltChangeStb, reqVoltMv, voltPermil, drawMa} =
      {2'h1, 16'h1388, 16'h1838, 16'h3E8};
    step(1);
    voltChangeStb = 1'b0;
    step(1990);
    chk("uv early", 16'h0, 16'(outputUndervoltageFault));
    waitSw(1'b0, 60);
    chk("uv fault", 16'h1, 16'(outputUndervoltageFault));
    chk("uv alert", 16'h0, 16'(alertReq));
    $display("test undervoltage done");
    tallyAndFinish();
  end
endmodule : tb_top
bind sfp_manager sfp_manager_checker #(.RESTART_CYCLES(RESTART_CYCLES)) sfp_manager_checker_i (
  .clk(clk), .srst(srst), .outVoltDivMv(outVoltDivMv), .reqVoltMv(reqVoltMv),
  .ppsContract(ppsContract), .voltChangeStb(voltChangeStb), .alertTaken(alertTaken),
  .cableOcPin(cableOcPin), .ccPullupEn(ccPullupEn), .vbusSwitchEn(vbusSwitchEn),
  .vconnEn(vconnEn), .cableLimited3A(cableLimited3A), .targetVoltMv(targetVoltMv),
  .ccLimitMode(ccLimitMode), .alertReq(alertReq), .alertOcp(alertOcp),
  .alertModeChange(alertModeChange), .outputOvervoltageFault(outputOvervoltageFault),
  .outputUndervoltageFault(outputUndervoltageFault), .overTempFault(overTempFault));
